//--- hdl/tec_timer.sv
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "tec_regs.svh"

// Function
// - ten channels, each a 16-bit timer, ch0-6 also event counters
// - modes: interval timer, event counter, pulse output, synchronous start
// - flip-flop output inversion set separately per group of four channels
// - capture latches counter for frequency, pulse width, time difference
// - channels identical except trigger routing, pins and interrupts
// - ch7 flip-flop captures ch0-1, ch8 ch2-4, ch9 ch5-6
// - ch0 starts ch0-3 together, ch4 starts ch4-7 together
// - slave start follows master prescaler run and counter run
// - each channel counts with a 16-bit up-counter
// - two 16-bit compare registers, one double-buffered
// - two 16-bit capture registers and two comparators per channel
// - timer flip-flop toggled by timer events, set, cleared or toggled by software
// - mode and flip-flop behaviour set by software registers
// - channels 7 to 9 have no capture interrupts
// - channels 7 to 9 take no external inputs
// - channels 7 to 9 drive no flip-flop pin
module tec_timer
    import tec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [`TEC_NPIN-1:0] ext_input_0,
    input wire logic [`TEC_NPIN-1:0] ext_input_1,
    output logic [`TEC_NPIN-1:0] flipflop_output,
    output logic [`TEC_NCH-1:0] channel_timer_interrupt,
    output logic [`TEC_NPIN-1:0] capture0_interrupt,
    output logic [`TEC_NPIN-1:0] capture1_interrupt,
    output logic irq
);

    // ************************************************************
    // storage
    // ************************************************************
    tec_cfg_t cfg [`TEC_NCH];
    logic [15:0] rg0 [`TEC_NCH];
    logic [15:0] rg1_buf [`TEC_NCH];
    logic [15:0] rg1 [`TEC_NCH];
    logic [15:0] cnt [`TEC_NCH];
    logic [15:0] cap0 [`TEC_NCH];
    logic [15:0] cap1 [`TEC_NCH];
    logic [`TEC_ST_W-1:0] st [`TEC_NCH];
    logic [`TEC_ST_W-1:0] im [`TEC_NCH];
    logic [`TEC_ST_W-1:0] st_clr [`TEC_NCH];
    tec_ff_cmd_t ff_cmd [`TEC_NCH];
    logic [`TEC_NCH-1:0] rg1_wr;
    logic [`TEC_NCH-1:0] ff;
    logic [`TEC_NCH-1:0] run_eff, prun_eff;
    logic [2:0] grp_inv;
    logic [`TEC_NCH-1:0] in0, in1, up_ff;

    // ************************************************************
    // bus slave
    // ************************************************************
    tec_bus_st_t bus_st;
    tec_bus_st_t next_bus_st;
    logic [9:0] a_addr;
    logic [3:0] a_ch;
    logic [5:0] a_ofs;
    logic accept;
    logic [31:0] next_rdata;

    assign accept = hsel && hready && htrans[1];
    assign a_ch = a_addr[9:`TEC_CH_STRIDE_LSB];
    assign a_ofs = a_addr[5:0];
    assign hresp = 1'b0;
    assign hreadyout = (bus_st != TEC_BUS_RWAIT);

    always_comb begin
        if (bus_st == TEC_BUS_RWAIT) begin
            next_bus_st = TEC_BUS_RDONE;
        end else if (accept) begin
            next_bus_st = hwrite ? TEC_BUS_WR : TEC_BUS_RWAIT;
        end else begin
            next_bus_st = TEC_BUS_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bus_st <= TEC_BUS_IDLE;
            a_addr <= 10'h000;
        end else begin
            bus_st <= next_bus_st;
            if (accept && bus_st != TEC_BUS_RWAIT) begin
                a_addr <= haddr[9:0];
            end
        end
    end

    // read back of control and state
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (a_addr == `TEC_OFS_GRP) begin
            next_rdata[2:0] = grp_inv;
        end else if (a_ch >= 4'(`TEC_NCH)) begin
            next_rdata = 32'h0000_0000;
        end else if (a_ofs == `TEC_OFS_EN) begin
            next_rdata[`TEC_EN_BIT] = cfg[a_ch].en;
        end else if (a_ofs == `TEC_OFS_RUN) begin
            next_rdata[`TEC_RUN_BIT] = cfg[a_ch].run;
            next_rdata[`TEC_PRUN_BIT] = cfg[a_ch].prun;
        end else if (a_ofs == `TEC_OFS_CR) begin
            next_rdata[`TEC_CR_SYNC_BIT] = cfg[a_ch].sync;
            next_rdata[`TEC_CR_DBUF_BIT] = cfg[a_ch].dbuf;
        end else if (a_ofs == `TEC_OFS_MOD) begin
            next_rdata[`TEC_MOD_CLK_LSB +: 2] = cfg[a_ch].clk_sel;
            next_rdata[`TEC_MOD_CLR_BIT] = cfg[a_ch].clr_en;
            next_rdata[`TEC_MOD_CAP_LSB +: 2] = cfg[a_ch].cap_sel;
        end else if (a_ofs == `TEC_OFS_FFCR) begin
            next_rdata[`TEC_FF_TRIG_LSB +: 4] = cfg[a_ch].ff_trig;
        end else if (a_ofs == `TEC_OFS_ST) begin
            next_rdata[`TEC_ST_W-1:0] = st[a_ch];
        end else if (a_ofs == `TEC_OFS_IM) begin
            next_rdata[`TEC_ST_W-1:0] = im[a_ch];
        end else if (a_ofs == `TEC_OFS_UC) begin
            next_rdata[15:0] = cnt[a_ch];
        end else if (a_ofs == `TEC_OFS_RG0) begin
            next_rdata[15:0] = rg0[a_ch];
        end else if (a_ofs == `TEC_OFS_RG1) begin
            next_rdata[15:0] = rg1_buf[a_ch];
        end else if (a_ofs == `TEC_OFS_CP0) begin
            next_rdata[15:0] = cap0[a_ch];
        end else if (a_ofs == `TEC_OFS_CP1) begin
            next_rdata[15:0] = cap1[a_ch];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_st == TEC_BUS_RWAIT) begin
            hrdata <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            grp_inv <= 3'h0;
            rg1_wr <= '0;
            for (int k = 0; k < `TEC_NCH; k++) begin
                cfg[k] <= '0;
                rg0[k] <= `TEC_RST_RG;
                rg1_buf[k] <= `TEC_RST_RG;
                im[k] <= '0;
                st_clr[k] <= '0;
                ff_cmd[k] <= TEC_FF_KEEP;
            end
        end else begin
            rg1_wr <= '0;
            for (int k = 0; k < `TEC_NCH; k++) begin
                st_clr[k] <= '0;
                ff_cmd[k] <= TEC_FF_KEEP;
            end
            if (bus_st == TEC_BUS_WR) begin
                if (a_addr == `TEC_OFS_GRP) begin
                    grp_inv <= hwdata[2:0];
                end else if (a_ch >= 4'(`TEC_NCH)) begin
                    grp_inv <= grp_inv;
                end else if (a_ofs == `TEC_OFS_EN) begin
                    cfg[a_ch].en <= hwdata[`TEC_EN_BIT];
                end else if (a_ofs == `TEC_OFS_RUN) begin
                    cfg[a_ch].run <= hwdata[`TEC_RUN_BIT];
                    cfg[a_ch].prun <= hwdata[`TEC_PRUN_BIT];
                end else if (a_ofs == `TEC_OFS_CR) begin
                    cfg[a_ch].sync <= hwdata[`TEC_CR_SYNC_BIT];
                    cfg[a_ch].dbuf <= hwdata[`TEC_CR_DBUF_BIT];
                end else if (a_ofs == `TEC_OFS_MOD) begin
                    cfg[a_ch].clk_sel <= tec_clk_sel_t'(hwdata[`TEC_MOD_CLK_LSB +: 2]);
                    cfg[a_ch].clr_en <= hwdata[`TEC_MOD_CLR_BIT];
                    cfg[a_ch].cap_sel <= tec_cap_sel_t'(hwdata[`TEC_MOD_CAP_LSB +: 2]);
                end else if (a_ofs == `TEC_OFS_FFCR) begin
                    cfg[a_ch].ff_trig <= hwdata[`TEC_FF_TRIG_LSB +: 4];
                    ff_cmd[a_ch] <= tec_ff_cmd_t'(hwdata[`TEC_FF_CMD_LSB +: 2]);
                end else if (a_ofs == `TEC_OFS_ST) begin
                    st_clr[a_ch] <= hwdata[`TEC_ST_W-1:0];
                end else if (a_ofs == `TEC_OFS_IM) begin
                    im[a_ch] <= hwdata[`TEC_ST_W-1:0];
                end else if (a_ofs == `TEC_OFS_RG0) begin
                    rg0[a_ch] <= hwdata[15:0];
                end else if (a_ofs == `TEC_OFS_RG1) begin
                    rg1_buf[a_ch] <= hwdata[15:0];
                    rg1_wr[a_ch] <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // channels
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < `TEC_NCH; i++) begin : g_ch
            localparam int MST = (i >= 1 && i <= 3) ? 0 : ((i >= 5 && i <= 7) ? 4 : i);
            localparam int UP = (i <= 1) ? 7 : ((i <= 4) ? 8 : ((i <= 6) ? 9 : i));
            logic [4:0] psc;
            logic tick, pre_tick, m0, m1;
            logic in0_q, in1_q, up_q, c0_ev, c1_ev;
            logic [`TEC_ST_W-1:0] set_ev;

            if (i < `TEC_NPIN) begin : g_pin
                assign in0[i] = ext_input_0[i];
                assign in1[i] = ext_input_1[i];
            end else begin : g_nopin
                assign in0[i] = 1'b0;
                assign in1[i] = 1'b0;
            end

            if (UP != i) begin : g_up
                assign up_ff[i] = ff[UP];
            end else begin : g_noup
                assign up_ff[i] = 1'b0;
            end

            if (MST != i) begin : g_slave
                assign run_eff[i] = cfg[i].sync
                    ? (cfg[i].run && cfg[MST].run && cfg[MST].prun) : cfg[i].run;
                assign prun_eff[i] = cfg[i].sync ? cfg[MST].prun : cfg[i].prun;
            end else begin : g_master
                assign run_eff[i] = cfg[i].run;
                assign prun_eff[i] = cfg[i].prun;
            end

            // prescaler
            always_ff @(posedge ref_clk) begin
                if (!rst_b || !cfg[i].en || !prun_eff[i]) begin
                    psc <= 5'h00;
                end else begin
                    psc <= psc + 5'h01;
                end
            end

            always_comb begin
                case (cfg[i].clk_sel)
                    TEC_CLK_DIV2: pre_tick = (psc[0:0] == 1'(`TEC_PSC_DIV2));
                    TEC_CLK_DIV8: pre_tick = (psc[2:0] == 3'(`TEC_PSC_DIV8));
                    TEC_CLK_DIV32: pre_tick = (psc == `TEC_PSC_DIV32);
                    default: pre_tick = in0[i] && !in0_q;
                endcase
            end

            // count source: prescaler or event edge
            assign tick = cfg[i].en && run_eff[i] && prun_eff[i] && pre_tick;
            assign m0 = tick && (cnt[i] == rg0[i]);
            assign m1 = tick && (cnt[i] == rg1[i]);

            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    in0_q <= 1'b0;
                    in1_q <= 1'b0;
                    up_q <= 1'b0;
                end else begin
                    in0_q <= in0[i];
                    in1_q <= in1[i];
                    up_q <= up_ff[i];
                end
            end

            always_comb begin
                c0_ev = 1'b0;
                c1_ev = 1'b0;
                case (cfg[i].cap_sel)
                    TEC_CAP_PINS: begin
                        c0_ev = in0[i] && !in0_q;
                        c1_ev = in1[i] && !in1_q;
                    end
                    TEC_CAP_IN0_BOTH: begin
                        c0_ev = in0[i] && !in0_q;
                        c1_ev = !in0[i] && in0_q;
                    end
                    TEC_CAP_UPPER_FF: begin
                        c0_ev = up_ff[i] && !up_q;
                        c1_ev = !up_ff[i] && up_q;
                    end
                    default: c0_ev = 1'b0;
                endcase
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_b || !cfg[i].en) begin
                    cnt[i] <= `TEC_RST_CNT;
                end else if (m1 && cfg[i].clr_en) begin
                    cnt[i] <= `TEC_RST_CNT;
                end else if (tick) begin
                    cnt[i] <= cnt[i] + 16'h0001;
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    rg1[i] <= `TEC_RST_RG;
                end else if (cfg[i].dbuf ? m1 : rg1_wr[i]) begin
                    rg1[i] <= rg1_buf[i];
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    cap0[i] <= `TEC_RST_CNT;
                    cap1[i] <= `TEC_RST_CNT;
                end else begin
                    if (c0_ev) begin
                        cap0[i] <= cnt[i];
                    end
                    if (c1_ev) begin
                        cap1[i] <= cnt[i];
                    end
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    ff[i] <= 1'b0;
                end else if (ff_cmd[i] == TEC_FF_SET) begin
                    ff[i] <= 1'b1;
                end else if (ff_cmd[i] == TEC_FF_CLR) begin
                    ff[i] <= 1'b0;
                end else if (ff_cmd[i] == TEC_FF_INV) begin
                    ff[i] <= !ff[i];
                end else if ((m0 && cfg[i].ff_trig[0]) ^ (m1 && cfg[i].ff_trig[1])
                        ^ (c0_ev && cfg[i].ff_trig[2]) ^ (c1_ev && cfg[i].ff_trig[3])) begin
                    ff[i] <= !ff[i];
                end
            end

            // status events, set wins over clear
            always_comb begin
                set_ev[`TEC_ST_M0] = m0;
                set_ev[`TEC_ST_M1] = m1;
                set_ev[`TEC_ST_OVF] = tick && (cnt[i] == `TEC_CNT_MAX) && !m1;
                // no capture status above channel 6
                set_ev[`TEC_ST_CAP0] = c0_ev && (i < `TEC_NPIN);
                set_ev[`TEC_ST_CAP1] = c1_ev && (i < `TEC_NPIN);
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_b) begin
                    st[i] <= `TEC_RST_ST;
                end else begin
                    st[i] <= (st[i] & ~st_clr[i]) | set_ev;
                end
            end

            // timer interrupt from match and overflow
            assign channel_timer_interrupt[i] =
                |(st[i][`TEC_ST_OVF:`TEC_ST_M0] & im[i][`TEC_ST_OVF:`TEC_ST_M0]);

            // per-group output mode, pins only below ch7
            if (i < `TEC_NPIN) begin : g_out
                always_ff @(posedge ref_clk) begin
                    if (!rst_b) begin
                        flipflop_output[i] <= 1'b0;
                    end else begin
                        flipflop_output[i] <= ff[i] ^ grp_inv[i / 4];
                    end
                end
                assign capture0_interrupt[i] = st[i][`TEC_ST_CAP0] && im[i][`TEC_ST_CAP0];
                assign capture1_interrupt[i] = st[i][`TEC_ST_CAP1] && im[i][`TEC_ST_CAP1];
            end
        end
    endgenerate

    // ************************************************************
    // combined interrupt
    // ************************************************************
    assign irq = |channel_timer_interrupt || |capture0_interrupt || |capture1_interrupt;

endmodule : tec_timer

//--- include/tec_pkg.sv
package tec_pkg;

    // capture trigger source selection
    typedef enum logic [1:0] {
        TEC_CAP_OFF = 2'h0,
        TEC_CAP_PINS = 2'h1,
        TEC_CAP_IN0_BOTH = 2'h2,
        TEC_CAP_UPPER_FF = 2'h3
    } tec_cap_sel_t;

    // count source selection
    typedef enum logic [1:0] {
        TEC_CLK_EVENT = 2'h0,
        TEC_CLK_DIV2 = 2'h1,
        TEC_CLK_DIV8 = 2'h2,
        TEC_CLK_DIV32 = 2'h3
    } tec_clk_sel_t;

    // flip-flop software command
    typedef enum logic [1:0] {
        TEC_FF_KEEP = 2'h0,
        TEC_FF_SET = 2'h1,
        TEC_FF_CLR = 2'h2,
        TEC_FF_INV = 2'h3
    } tec_ff_cmd_t;

    // bus slave states, gray along idle-read path
    typedef enum logic [1:0] {
        TEC_BUS_IDLE = 2'b00,
        TEC_BUS_RWAIT = 2'b01,
        TEC_BUS_RDONE = 2'b11,
        TEC_BUS_WR = 2'b10
    } tec_bus_st_t;

    typedef struct packed {
        logic en;
        logic run;
        logic prun;
        logic sync;
        logic dbuf;
        tec_clk_sel_t clk_sel;
        logic clr_en;
        tec_cap_sel_t cap_sel;
        logic [3:0] ff_trig;
    } tec_cfg_t;

endpackage : tec_pkg

//--- include/tec_regs.svh
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

// ************************************************************
// array geometry
// ************************************************************
`define TEC_NCH 10
`define TEC_NPIN 7
`define TEC_CH_STRIDE_LSB 6

// ************************************************************
// per-channel register offsets (byte address bits [5:0]), group register full address
// ************************************************************
`define TEC_OFS_EN 6'h00
`define TEC_OFS_RUN 6'h04
`define TEC_OFS_CR 6'h08
`define TEC_OFS_MOD 6'h0C
`define TEC_OFS_FFCR 6'h10
`define TEC_OFS_ST 6'h14
`define TEC_OFS_IM 6'h18
`define TEC_OFS_UC 6'h1C
`define TEC_OFS_RG0 6'h20
`define TEC_OFS_RG1 6'h24
`define TEC_OFS_CP0 6'h28
`define TEC_OFS_CP1 6'h2C
`define TEC_OFS_GRP 10'h280

// ************************************************************
// field positions
// ************************************************************
`define TEC_EN_BIT 0
`define TEC_RUN_BIT 0
`define TEC_PRUN_BIT 2
`define TEC_CR_SYNC_BIT 0
`define TEC_CR_DBUF_BIT 1
`define TEC_MOD_CLK_LSB 0
`define TEC_MOD_CLR_BIT 2
`define TEC_MOD_CAP_LSB 3
`define TEC_FF_CMD_LSB 0
`define TEC_FF_TRIG_LSB 2
`define TEC_ST_M0 0
`define TEC_ST_M1 1
`define TEC_ST_OVF 2
`define TEC_ST_CAP0 3
`define TEC_ST_CAP1 4
`define TEC_ST_W 5

// ************************************************************
// reset values and counts
// ************************************************************
`define TEC_RST_CNT 16'h0000
`define TEC_RST_RG 16'hFFFF
`define TEC_RST_ST 5'h00
`define TEC_CNT_MAX 16'hFFFF
`define TEC_PSC_DIV2 5'h01
`define TEC_PSC_DIV8 5'h07
`define TEC_PSC_DIV32 5'h1F
`define TEC_HTRANS_NONSEQ 2'h2

`endif

//--- test/tec_pins_model.sv
`timescale 1ns/1ps
module tec_pins_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [6:0] pulse0,
    input wire logic [6:0] pulse1,
    output logic [6:0] ext_input_0,
    output logic [6:0] ext_input_1
);
    logic [6:0] d0a;
    logic [6:0] d0b;
    logic [6:0] d1a;
    logic [6:0] d1b;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            {d0a, d0b, d1a, d1b, ext_input_0, ext_input_1} <= '0;
        end else begin
            d0a <= pulse0;
            d0b <= d0a;
            d1a <= pulse1;
            d1b <= d1a;
            ext_input_0 <= pulse0 | d0a | d0b;
            ext_input_1 <= pulse1 | d1a | d1b;
        end
    end
endmodule : tec_pins_model

//--- test/tec_timer_properties.sv
`timescale 1ns/1ps
module tec_timer_checker (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [6:0] flipflop_output,
    input wire logic [9:0] channel_timer_interrupt,
    input wire logic [6:0] capture0_interrupt,
    input wire logic [6:0] capture1_interrupt,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // ****************
    // bus and outputs
    // ****************
    sequence s_rd_taken;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_wr_taken;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    AST_READ_ONE_WAIT: assert property (s_rd_taken |=> s_one_wait)
        else $error("read not answered after one wait");
    AST_WRITE_NO_WAIT: assert property (s_wr_taken |=> hreadyout)
        else $error("write stalled");
    AST_ONLY_READS_WAIT: assert property (!hready || !hsel || !htrans[1] || hwrite
        |=> hreadyout)
        else $error("wait state without read");
    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_IRQ_OR: assert property (irq == (|channel_timer_interrupt ||
        |capture0_interrupt || |capture1_interrupt))
        else $error("irq not the or of interrupts");
    AST_RESET_QUIET: assert property ($rose(rst_b) |-> hreadyout && !irq &&
        flipflop_output == 7'h00)
        else $error("outputs not cleared by reset");
    AST_HRDATA_STANDS: assert property (!$stable(hrdata) |-> !$past(hreadyout))
        else $error("read data changed outside a read");
    AST_CAP_SEEN: assert property ($rose(capture0_interrupt[2]) |-> irq)
        else $error("capture interrupt without irq");
endmodule : tec_timer_checker

bind tec_timer tec_timer_checker i_tec_timer_checker (.ref_clk(ref_clk), .rst_b(rst_b),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .flipflop_output(flipflop_output), .channel_timer_interrupt(channel_timer_interrupt),
    .capture0_interrupt(capture0_interrupt), .capture1_interrupt(capture1_interrupt),
    .irq(irq));

//--- test/testbench.sv
`timescale 1ns/1ps
`include "tec_regs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
`define WAITB(x) for (int k = 0; k < 200 && !(x); k++) @(posedge ref_clk);
module testbench;
    import tec_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata, rv, v;
    logic [6:0] in0, in1, ffo, cap0, cap1;
    logic [6:0] pulse0 = 7'h00;
    logic [6:0] pulse1 = 7'h00;
    logic [9:0] tint;
    int err_total = 0;
    int n_compared = 0;
    logic [63:0] note_q[$];
    logic [63:0] nt;
    logic rd_dp = 1'b0;
    always #25 ref_clk = ~ref_clk;
    tec_timer i_tec_timer (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_input_0(in0), .ext_input_1(in1), .flipflop_output(ffo),
        .channel_timer_interrupt(tint), .capture0_interrupt(cap0),
        .capture1_interrupt(cap1), .irq(irq));
    tec_pins_model i_tec_pins_model (.ref_clk(ref_clk), .rst_b(rst_b), .pulse0(pulse0),
        .pulse1(pulse1), .ext_input_0(in0), .ext_input_1(in1));
    // ****************
    // read monitor
    // ****************
    always @(posedge ref_clk) begin
        if (rd_dp && hreadyout && note_q.size() > 0) begin
            nt = note_q.pop_front();
            if (nt[63:32] != 32'h0) `CHK(hrdata & nt[63:32], nt[31:0])
        end
        if (hreadyout) rd_dp <= hsel && htrans[1] && !hwrite;
    end
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= `TEC_HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge ref_clk iff hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk iff hreadyout);
        rv = hrdata;
    endtask : xfer
    task automatic wr(input int c, input logic [9:0] o, input logic [31:0] d);
        xfer(1'b1, 10'(c * 64) + o, d);
    endtask : wr
    task automatic rd(input int c, input logic [9:0] o, input logic [31:0] e,
        input logic [31:0] m);
        note_q.push_back({m, e});
        xfer(1'b0, 10'(c * 64) + o, 32'h0000_0000);
    endtask : rd
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #1_000_000;
        err_total++;
        tally_and_finish();
    end
    // ****************
    // tests
    // ****************
    initial begin
        void'($urandom(58));
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rd(0, `TEC_OFS_RG0, 32'h0000_FFFF, 32'hFFFF_FFFF);
        rd(9, `TEC_OFS_UC, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(12, 10'h000, 32'h0000_0000, 32'hFFFF_FFFF);
        for (int c = 0; c < 10; c++) begin
            v = $urandom();
            wr(c, `TEC_OFS_RG0, v);
            rd(c, `TEC_OFS_RG0, {16'h0000, v[15:0]}, 32'hFFFF_FFFF);
        end
        $display("test reset_regs done");
        wr(3, `TEC_OFS_RG1, 32'h0000_0005);
        wr(3, `TEC_OFS_MOD, 32'h0000_0005);
        wr(3, `TEC_OFS_IM, 32'h0000_0002);
        wr(3, `TEC_OFS_EN, 32'h0000_0001);
        wr(3, `TEC_OFS_RUN, 32'h0000_0005);
        `WAITB(tint[3])
        `CHK(tint[3], 1'b1)
        `CHK(irq, 1'b1)
        repeat (40) @(posedge ref_clk);
        wr(3, `TEC_OFS_RUN, 32'h0000_0000);
        rd(3, `TEC_OFS_UC, 32'h0000_0000, 32'h0000_FFF8);
        wr(3, `TEC_OFS_ST, 32'h0000_001F);
        rd(3, `TEC_OFS_ST, 32'h0000_0000, 32'h0000_0002);
        `CHK(tint[3], 1'b0)
        $display("test interval done");
        wr(2, `TEC_OFS_MOD, 32'h0000_0009);
        wr(2, `TEC_OFS_IM, 32'h0000_0018);
        wr(2, `TEC_OFS_EN, 32'h0000_0001);
        wr(2, `TEC_OFS_RUN, 32'h0000_0005);
        repeat (20) @(posedge ref_clk);
        wr(2, `TEC_OFS_RUN, 32'h0000_0000);
        rd(2, `TEC_OFS_UC, 32'h0000_0000, 32'h0000_0000);
        v = rv;
        pulse0 <= 7'h04;
        pulse1 <= 7'h04;
        @(posedge ref_clk);
        pulse0 <= 7'h00;
        pulse1 <= 7'h00;
        `WAITB(cap0[2] && cap1[2])
        `CHK(cap0[2], 1'b1)
        `CHK(cap1[2], 1'b1)
        rd(2, `TEC_OFS_CP0, v, 32'hFFFF_FFFF);
        rd(2, `TEC_OFS_CP1, v, 32'hFFFF_FFFF);
        $display("test capture done");
        wr(2, `TEC_OFS_MOD, 32'h0000_0019);
        wr(2, `TEC_OFS_ST, 32'h0000_001F);
        wr(8, `TEC_OFS_FFCR, 32'h0000_0001);
        `WAITB(cap0[2])
        rd(2, `TEC_OFS_ST, 32'h0000_0008, 32'h0000_0018);
        wr(8, `TEC_OFS_FFCR, 32'h0000_0002);
        `WAITB(cap1[2])
        rd(2, `TEC_OFS_ST, 32'h0000_0018, 32'h0000_0018);
        $display("test upper_trigger done");
        wr(1, `TEC_OFS_CR, 32'h0000_0001);
        wr(1, `TEC_OFS_MOD, 32'h0000_0002);
        wr(1, `TEC_OFS_EN, 32'h0000_0001);
        wr(1, `TEC_OFS_RUN, 32'h0000_0001);
        repeat (20) @(posedge ref_clk);
        rd(1, `TEC_OFS_UC, 32'h0000_0000, 32'h0000_FFFF);
        wr(0, `TEC_OFS_EN, 32'h0000_0001);
        wr(0, `TEC_OFS_RUN, 32'h0000_0005);
        repeat (20) @(posedge ref_clk);
        rd(1, `TEC_OFS_UC, 32'h0000_0000, 32'h0000_0000);
        `CHK(rv != 32'h0000_0000, 1'b1)
        $display("test sync_start done");
        wr(0, `TEC_OFS_FFCR, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
        `CHK(ffo[0], 1'b1)
        wr(0, `TEC_OFS_FFCR, 32'h0000_0003);
        repeat (3) @(posedge ref_clk);
        `CHK(ffo[0], 1'b0)
        xfer(1'b1, `TEC_OFS_GRP, 32'h0000_0001);
        repeat (3) @(posedge ref_clk);
        `CHK(ffo[3:0], 4'hF)
        $display("test flipflop done");
        wr(4, `TEC_OFS_MOD, 32'h0000_0010);
        wr(4, `TEC_OFS_FFCR, 32'h0000_0010);
        wr(4, `TEC_OFS_EN, 32'h0000_0001);
        wr(4, `TEC_OFS_RUN, 32'h0000_0005);
        pulse0 <= 7'h10;
        @(posedge ref_clk);
        pulse0 <= 7'h00;
        repeat (8) @(posedge ref_clk);
        `CHK(ffo[4], 1'b1)
        rd(4, `TEC_OFS_UC, 32'h0000_0001, 32'hFFFF_FFFF);
        rd(4, `TEC_OFS_CP0, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(4, `TEC_OFS_CP1, 32'h0000_0001, 32'hFFFF_FFFF);
        $display("test event_width done");
        tally_and_finish();
    end
endmodule : testbench
